//--- bench/psm_clock_ctrl_tb.sv
// self-checking bench for the power saving clock control
`timescale 1ns/1ps
module psm_clock_ctrl_tb;
  import psm_pkg::*;

  logic                       clk_i     = 1'b0;
  logic                       rst_n_i   = 1'b0;
  logic                       valid     = 1'b0;
  logic [1:0]                 req_code  = 2'h0;
  logic [PSM_CMC_W-1:0]       cmc       = 8'h00;
  logic [PSM_NUM_MODULES-1:0] stop      = 8'h00;
  logic                       irq_wake  = 1'b0;
  logic                       wake_pin  = 1'b0;
  logic                       pll_lock  = 1'b1;
  logic                       cpu_clk_en_o;
  logic [PSM_NUM_MODULES-1:0] per_clk_en_o;
  logic                       osc_en_o;
  logic                       pll_en_o;
  logic [2:0]                 mode_o;
  int                         n_mismatch = 0;
  int                         cmp_count  = 0;
  int                         cycles     = 0;

  always #20 clk_i = ~clk_i;

  psm_clock_ctrl psm_clock_ctrl_i (
    .clk_i                (clk_i),
    .rst_n_i              (rst_n_i),
    .mode_req_valid_i     (valid),
    .mode_req_i           (req_code),
    .clock_mode_control_i (cmc),
    .module_clk_stop_i    (stop),
    .irq_wake_i           (irq_wake),
    .wake_pin_i           (wake_pin),
    .pll_lock_i           (pll_lock),
    .cpu_clk_en_o         (cpu_clk_en_o),
    .per_clk_en_o         (per_clk_en_o),
    .osc_en_o             (osc_en_o),
    .pll_en_o             (pll_en_o),
    .mode_o               (mode_o)
  );

  function automatic logic [7:0] exp_per(input logic [7:0] s);
    return ~s;
  endfunction

  function automatic logic [7:0] slow_period(input logic [3:0] f);
    return {4'h0, f} + 8'h01;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic req(input logic [1:0] code);
    @(negedge clk_i);
    valid    = 1'b1;
    req_code = code;
    @(negedge clk_i);
    valid    = 1'b0;
  endtask

  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    while (mode_o !== m && k < 64) begin
      @(negedge clk_i);
      k++;
    end
  endtask

  task automatic run_slow(input logic [3:0] f);
    int gap;
    int k;
    cmc = {4'h0, f};
    req(PSM_REQ_SLOW);
    chk_vec({5'h0, mode_o}, 8'h02);
    chk_bit(osc_en_o, 1'b1);
    k = 0;
    while (cpu_clk_en_o !== 1'b1 && k < 40) begin
      @(negedge clk_i);
      k++;
    end
    chk_vec(per_clk_en_o, 8'hFF);
    gap = 0;
    do begin
      @(negedge clk_i);
      gap++;
      if (cpu_clk_en_o !== 1'b1) chk_vec(per_clk_en_o, 8'h00);
    end while (cpu_clk_en_o !== 1'b1 && gap < 40);
    chk_vec(8'(gap), slow_period(f));
    req(PSM_REQ_IDLE);
    chk_vec({5'h0, mode_o}, 8'h02);
    @(negedge clk_i);
    valid    = 1'b1;
    req_code = PSM_REQ_ACTIVE;
    wait_mode(PSM_ACTIVE);
    valid = 1'b0;
    chk_bit(cpu_clk_en_o, 1'b1);
    chk_vec(per_clk_en_o, 8'hFF);
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'hC436));
    repeat (20) @(negedge clk_i);
    chk_vec({5'h0, mode_o}, 8'h00);
    chk_bit(cpu_clk_en_o & osc_en_o & pll_en_o, 1'b1);
    chk_vec(per_clk_en_o, 8'hFF);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk_vec(per_clk_en_o, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      stop = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      @(negedge clk_i);
      @(negedge clk_i);
      chk_vec(per_clk_en_o, exp_per(stop));
      chk_bit(cpu_clk_en_o, 1'b1);
    end
    req(PSM_REQ_IDLE);
    chk_vec({5'h0, mode_o}, 8'h01);
    chk_bit(cpu_clk_en_o, 1'b0);
    chk_bit(osc_en_o & pll_en_o, 1'b1);
    chk_vec(per_clk_en_o, exp_per(stop));
    req(PSM_REQ_PDOWN);
    chk_vec({5'h0, mode_o}, 8'h01);
    irq_wake = 1'b1;
    @(negedge clk_i);
    irq_wake = 1'b0;
    chk_vec({5'h0, mode_o}, 8'h00);
    chk_bit(cpu_clk_en_o, 1'b1);
    req(PSM_REQ_IDLE);
    chk_vec({5'h0, mode_o}, 8'h01);
    wake_pin = 1'b1;
    wait_mode(PSM_ACTIVE);
    chk_vec({5'h0, mode_o}, 8'h00);
    chk_bit(cpu_clk_en_o, 1'b1);
    wake_pin = 1'b0;
    stop = 8'h00;
    run_slow(4'h0);
    run_slow(4'hF);
    run_slow(4'($urandom_range(1, 14)));
    pll_lock = 1'b0;
    req(PSM_REQ_PDOWN);
    chk_vec({5'h0, mode_o}, 8'h03);
    chk_bit(osc_en_o | pll_en_o, 1'b0);
    chk_bit(cpu_clk_en_o, 1'b0);
    chk_vec(per_clk_en_o, 8'h00);
    repeat (6) @(negedge clk_i);
    chk_bit(osc_en_o | pll_en_o, 1'b0);
    wake_pin = 1'b1;
    wait_mode(PSM_WAKE);
    chk_vec({5'h0, mode_o}, 8'h04);
    chk_bit(osc_en_o & pll_en_o, 1'b1);
    chk_bit(cpu_clk_en_o, 1'b0);
    pll_lock = 1'b1;
    wait_mode(PSM_ACTIVE);
    wake_pin = 1'b0;
    chk_vec({5'h0, mode_o}, 8'h00);
    chk_bit(cpu_clk_en_o, 1'b1);
    chk_vec(per_clk_en_o, 8'hFF);
    req(PSM_REQ_PDOWN);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chk_vec({5'h0, mode_o}, 8'h00);
    chk_bit(cpu_clk_en_o & osc_en_o & pll_en_o, 1'b1);
    chk_vec(per_clk_en_o, 8'hFF);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_vec({5'h0, mode_o}, 8'h00);
    chk_bit(cpu_clk_en_o & osc_en_o & pll_en_o, 1'b1);
    tally_and_finish();
  end
endmodule

//--- design/psm_clock_ctrl.sv
// power saving mode clock control: idle, slow-down, power-down
`timescale 1ns/1ps
module psm_clock_ctrl (
  input  wire logic                                clk_i,
  input  wire logic                                rst_n_i,
  input  wire logic                                mode_req_valid_i,
  input  wire logic [1:0]                          mode_req_i,
  input  wire logic [psm_pkg::PSM_CMC_W-1:0]       clock_mode_control_i,
  input  wire logic [psm_pkg::PSM_NUM_MODULES-1:0] module_clk_stop_i,
  input  wire logic                                irq_wake_i,
  input  wire logic                                wake_pin_i,
  input  wire logic                                pll_lock_i,
  output logic                                     cpu_clk_en_o,
  output logic [psm_pkg::PSM_NUM_MODULES-1:0]      per_clk_en_o,
  output logic                                     osc_en_o,
  output logic                                     pll_en_o,
  output logic [2:0]                               mode_o
);
  import psm_pkg::*;

  typedef struct packed {
    psm_mode_e                  mode;
    logic                       cpu_en;
    logic [PSM_NUM_MODULES-1:0] per_en;
    logic                       osc_en;
    logic                       pll_en;
    logic [2:0]                 wake_sh;
    logic                       wake_f;
    logic [2:0]                 lock_sh;
    logic                       lock_f;
  } psm_ctl_s;

  psm_ctl_s ctl_ff;
  psm_ctl_s nxt_ctl;

  logic                 div_restart;
  logic                 div_tick;
  logic [PSM_DIV_W-1:0] div_factor;

  assign div_factor = clock_mode_control_i[PSM_DIV_MSB:PSM_DIV_LSB];

  psm_divider psm_divider_i (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .restart_i (div_restart),
    .factor_i  (div_factor),
    .tick_o    (div_tick)
  );

  logic      base_tick;
  logic      wake_rise;
  psm_mode_e mode_nx;

  always_comb begin
    nxt_ctl = ctl_ff;
    // pin inputs: three stages, change taken when stages two and three agree
    nxt_ctl.wake_sh = {ctl_ff.wake_sh[1:0], wake_pin_i};
    nxt_ctl.lock_sh = {ctl_ff.lock_sh[1:0], pll_lock_i};
    if (ctl_ff.wake_sh[1] == ctl_ff.wake_sh[2]) begin
      nxt_ctl.wake_f = ctl_ff.wake_sh[2];
    end
    if (ctl_ff.lock_sh[1] == ctl_ff.lock_sh[2]) begin
      nxt_ctl.lock_f = ctl_ff.lock_sh[2];
    end
    wake_rise = nxt_ctl.wake_f && !ctl_ff.wake_f;

    mode_nx     = ctl_ff.mode;
    div_restart = 1'b0;
    unique case (ctl_ff.mode)
      PSM_ACTIVE: begin
        if (mode_req_valid_i) begin
          unique case (mode_req_i)
            PSM_REQ_IDLE:   mode_nx = PSM_IDLE;
            PSM_REQ_SLOW: begin
              mode_nx     = PSM_SLOW;
              div_restart = 1'b1;
            end
            PSM_REQ_PDOWN:  mode_nx = PSM_PDOWN;
            PSM_REQ_ACTIVE: mode_nx = PSM_ACTIVE;
          endcase
        end
      end
      PSM_IDLE: begin
        if (irq_wake_i || wake_rise) begin
          mode_nx = PSM_ACTIVE;
        end
      end
      PSM_SLOW: begin
        // back to full speed only on a slow period boundary
        if (mode_req_valid_i && mode_req_i == PSM_REQ_ACTIVE) begin
          mode_nx = PSM_ACTIVE;
        end
      end
      PSM_PDOWN: begin
        if (wake_rise) begin
          mode_nx = PSM_WAKE;
        end
      end
      PSM_WAKE: begin
        // clocks held until the PLL reports lock again
        if (ctl_ff.lock_f) begin
          mode_nx = PSM_ACTIVE;
        end
      end
      default: mode_nx = PSM_ACTIVE;
    endcase
    if (ctl_ff.mode == PSM_SLOW && mode_nx == PSM_ACTIVE && !div_tick) begin
      mode_nx = PSM_SLOW;
    end
    nxt_ctl.mode = mode_nx;

    base_tick = (mode_nx == PSM_SLOW) ? div_tick : 1'b1;
    if (mode_nx == PSM_SLOW && ctl_ff.mode != PSM_SLOW) begin
      base_tick = 1'b0;
    end
    nxt_ctl.osc_en = (mode_nx != PSM_PDOWN);
    nxt_ctl.pll_en = (mode_nx != PSM_PDOWN);
    nxt_ctl.cpu_en = base_tick && (mode_nx != PSM_IDLE)
                     && (mode_nx != PSM_PDOWN) && (mode_nx != PSM_WAKE);
    nxt_ctl.per_en = {PSM_NUM_MODULES{base_tick}} & ~module_clk_stop_i;
    if (mode_nx == PSM_PDOWN || mode_nx == PSM_WAKE) begin
      nxt_ctl.per_en = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_ff <= '{mode: PSM_ACTIVE, cpu_en: 1'b1,
                  per_en: ~PSM_STOP_RST, osc_en: 1'b1, pll_en: 1'b1,
                  wake_sh: 3'h0, wake_f: 1'b0,
                  lock_sh: 3'h0, lock_f: 1'b0};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign cpu_clk_en_o = ctl_ff.cpu_en;
  assign per_clk_en_o = ctl_ff.per_en;
  assign osc_en_o     = ctl_ff.osc_en;
  assign pll_en_o     = ctl_ff.pll_en;
  assign mode_o       = ctl_ff.mode;

  // helper: cycles since last cpu pulse while slowed
  // gap_valid: a full period started, entry latency excluded
  logic [PSM_DIV_W:0] gap_cnt;
  logic               gap_valid;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_cnt   <= '0;
      gap_valid <= 1'b0;
    end else if (ctl_ff.cpu_en || ctl_ff.mode != PSM_SLOW) begin
      gap_cnt   <= '0;
      gap_valid <= (ctl_ff.mode == PSM_SLOW);
    end else begin
      gap_cnt <= gap_cnt + 5'h01;
    end
  end

  sequence s_pdown_entry;
    ctl_ff.mode == PSM_ACTIVE && mode_req_valid_i
      && mode_req_i == PSM_REQ_PDOWN;
  endsequence

  sequence s_oscs_off;
    !osc_en_o && !pll_en_o && !cpu_clk_en_o && per_clk_en_o == 8'h00;
  endsequence

  chk_reset_active: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> mode_o == PSM_ACTIVE && cpu_clk_en_o)
    else $error("not active with full clock after reset");

  chk_active_full: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_o == PSM_ACTIVE && $past(mode_o) == PSM_ACTIVE) |-> cpu_clk_en_o)
    else $error("processor clock gated in active mode");

  chk_mode_request: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ctl_ff.mode == PSM_ACTIVE && mode_req_valid_i
      && mode_req_i == PSM_REQ_IDLE) |=> mode_o == PSM_IDLE)
    else $error("idle request from active not taken");

  chk_idle_cpu_only: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    mode_o == PSM_IDLE |-> !cpu_clk_en_o && osc_en_o && pll_en_o
      && per_clk_en_o == ~$past(module_clk_stop_i))
    else $error("idle gated more than the processor clock");

  chk_slow_shared: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_o == PSM_SLOW && cpu_clk_en_o) |->
      per_clk_en_o == ~$past(module_clk_stop_i))
    else $error("peripheral and processor slow ticks disagree");

  chk_pdown_off: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_pdown_entry |=> s_oscs_off)
    else $error("power-down left a clock source running");

  chk_module_stop: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_o == PSM_ACTIVE && $past(mode_o) == PSM_ACTIVE)
      |-> per_clk_en_o == ~$past(module_clk_stop_i))
    else $error("module clock stop not applied alone");

  chk_no_short_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ($rose(cpu_clk_en_o) && gap_valid)
      |-> gap_cnt == {1'b0, $past(psm_divider_i.div_ff.fac, 2)})
    else $error("slow period shorter or longer than the factor");

  chk_wake_lock: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_o == PSM_WAKE && !ctl_ff.lock_f) |=> mode_o == PSM_WAKE)
    else $error("wake state left before the PLL reported lock");

endmodule

//--- design/psm_divider.sv
// slow-down divider producing a one-cycle enable pulse per period
`timescale 1ns/1ps
module psm_divider (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          restart_i,
  input  wire logic [psm_pkg::PSM_DIV_W-1:0] factor_i,
  output logic                               tick_o
);
  import psm_pkg::*;

  typedef struct packed {
    logic [PSM_DIV_W-1:0] cnt;
    logic [PSM_DIV_W-1:0] fac;
    logic                 tick;
  } psm_div_s;

  psm_div_s div_ff;
  psm_div_s nxt_div;

  always_comb begin
    nxt_div = div_ff;
    if (restart_i) begin
      nxt_div.cnt  = '0;
      nxt_div.fac  = factor_i;
      nxt_div.tick = 1'b0;
    end else if (div_ff.cnt == div_ff.fac) begin
      // new factor taken only at a period boundary or on restart
      nxt_div.cnt  = '0;
      nxt_div.fac  = factor_i;
      nxt_div.tick = 1'b1;
    end else begin
      nxt_div.cnt  = div_ff.cnt + 4'h1;
      nxt_div.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= '{cnt: 4'h0, fac: PSM_DIV_RST, tick: 1'b0};
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign tick_o = div_ff.tick;

  chk_div_period: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (div_ff.tick && !restart_i && div_ff.fac != 4'h0)
      |=> !div_ff.tick)
    else $error("divider tick repeated before period end");

endmodule

//--- design/psm_pkg.sv
// shared constants and types for the power saving clock control
package psm_pkg;

  localparam int unsigned PSM_NUM_MODULES = 8;
  localparam int unsigned PSM_DIV_W       = 4;
  localparam int unsigned PSM_CMC_W       = 8;

  // clock_mode_control field layout
  localparam int unsigned PSM_DIV_LSB = 0;
  localparam int unsigned PSM_DIV_MSB = 3;

  // reset values
  localparam logic [PSM_DIV_W-1:0] PSM_DIV_RST  = 4'h0;
  localparam logic [7:0]           PSM_STOP_RST = 8'h00;

  // requested mode codes on mode_req_i
  localparam logic [1:0] PSM_REQ_ACTIVE = 2'h0;
  localparam logic [1:0] PSM_REQ_IDLE   = 2'h1;
  localparam logic [1:0] PSM_REQ_SLOW   = 2'h2;
  localparam logic [1:0] PSM_REQ_PDOWN  = 2'h3;

  typedef enum logic [2:0] {
    PSM_ACTIVE = 3'b000,
    PSM_IDLE   = 3'b001,
    PSM_SLOW   = 3'b010,
    PSM_PDOWN  = 3'b011,
    PSM_WAKE   = 3'b100
  } psm_mode_e;

endpackage
